//--- mfe_pkg.sv
// Constants, types and shared decoding for the MAC enable and station address block.
// Assumes an APB slave with 32-bit data and byte addresses of 8 bits.
//
// Notes on behaviour
// - Transmit enable set: buffer frames go out.
// - Transmit enable clear: no frame is sent; a frame already started still runs to its last byte.
// - Receive enable set: incoming PHY frames accepted.
// - Address high word: read/write, reset 0000fff.
// - Bits 15:0 hold address 47:32; upper reserved.
// - Programmed EEPROM loads address high at power-on.
// - EEPROM byte 0x05 feeds bits 7:0.
// - EEPROM byte 0x06 feeds bits 15:8.
// - Host may overwrite address after initialization.
// - Address low from EEPROM bytes 0x01-0x04.
package mfe_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register indices and byte addresses.
  localparam logic [7:0] REG_CTRL_IDX = 8'h01;
  localparam logic [7:0] REG_STATION_ADDR_HIGH_IDX = 8'h02;
  localparam logic [7:0] REG_STATION_ADDR_LOW_IDX = 8'h03;
  localparam logic [7:0] REG_STATUS_IDX = 8'h08;
  localparam logic [7:0] REG_CTRL_ADDR = 8'h04;
  localparam logic [7:0] REG_STATION_ADDR_HIGH_ADDR = 8'h08;
  localparam logic [7:0] REG_STATION_ADDR_LOW_ADDR = 8'h0c;
  localparam logic [7:0] REG_STATUS_ADDR = 8'h20;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions and values after reset.
  localparam int CTRL_TRANSMIT_ENABLE_BIT_BIT = 3;
  localparam int CTRL_RECEIVE_ENABLE_BIT_BIT = 2;
  localparam int STAT_INIT_BIT = 0;
  localparam int STAT_TXBUSY_BIT = 1;
  localparam logic CTRL_TRANSMIT_ENABLE_BIT_RESET = 1'b0;
  localparam logic CTRL_RECEIVE_ENABLE_BIT_RESET = 1'b0;
  localparam logic [31:0] STATION_ADDR_HIGH_RESET = 32'h0000_0fff;
  localparam logic [31:0] STATION_ADDR_LOW_RESET = 32'h0fff_ffff;

  //////////////////////////////////////////////////////////////////////////////
  // EEPROM byte addresses of the station address.
  localparam logic [7:0] EE_STATION_ADDR_LOW_B0 = 8'h01;
  localparam logic [7:0] EE_STATION_ADDR_LOW_B1 = 8'h02;
  localparam logic [7:0] EE_STATION_ADDR_LOW_B2 = 8'h03;
  localparam logic [7:0] EE_STATION_ADDR_LOW_B3 = 8'h04;
  localparam logic [7:0] EE_STATION_ADDR_HIGH_B0 = 8'h05;
  localparam logic [7:0] EE_STATION_ADDR_HIGH_B1 = 8'h06;

  //////////////////////////////////////////////////////////////////////////////
  // Frame byte positions: destination 0..5, source 6..11.
  localparam logic [3:0] SRC_FIRST = 4'h6;
  localparam logic [3:0] SRC_END = 4'hc;
  localparam logic [3:0] DST_END = 4'h6;

  typedef enum logic [0:0] {
    MFE_TX_IDLE = 1'b0,
    MFE_TX_SEND = 1'b1
  } mfe_tx_state_e;

  typedef enum logic [1:0] {
    MFE_RX_IDLE = 2'b00,
    MFE_RX_ACCEPT = 2'b01,
    MFE_RX_DROP = 2'b10
  } mfe_rx_state_e;

  // Byte k of the station address in wire order; byte 0 goes first.
  function automatic logic [7:0] mfe_addr_byte(input logic [47:0] addr, input logic [2:0] k);
    mfe_addr_byte = addr[{k, 3'b000} +: 8];
  endfunction : mfe_addr_byte

endpackage : mfe_pkg

//--- mfe_rx_if.sv
// Interface between the register block and the receive filter.
// Assumes both ends run on core_clk with the synchronised reset.
`timescale 1ns/1ns
interface mfe_rx_if;
  logic [47:0] stationAddr;
  logic rxEnable;
  logic inValid;
  logic [7:0] inData;
  logic inLast;
  logic outValid;
  logic [7:0] outData;
  logic outLast;
  logic frameDone;
  logic destMatch;

  // The register block drives the address, enable and PHY bytes.
  modport mac (
    output stationAddr, rxEnable, inValid, inData, inLast,
    input outValid, outData, outLast, frameDone, destMatch
  );

  // The filter consumes them and returns accepted bytes.
  modport filt (
    input stationAddr, rxEnable, inValid, inData, inLast,
    output outValid, outData, outLast, frameDone, destMatch
  );
endinterface : mfe_rx_if

//--- mfe_rx_filter.sv
// Receive gate and destination address comparator.
// Assumes the PHY pushes one byte per valid cycle with no back-pressure.
`timescale 1ns/1ns
module mfe_rx_filter (
  // Clock and synchronised reset.
  input wire logic core_clk,
  input wire logic rstSync,
  // Link to the register block.
  mfe_rx_if.filt rx
);

  mfe_pkg::mfe_rx_state_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic match, next_match;
  logic outValid, next_outValid;
  logic [7:0] outData, next_outData;
  logic outLast, next_outLast;
  logic frameDone, next_frameDone;
  logic destMatch, next_destMatch;
  logic accept;
  logic matchNow;

  // Decide per byte whether the frame is taken and whether its destination matches.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_match = match;
    next_outValid = 1'b0;
    next_outData = outData;
    next_outLast = 1'b0;
    next_frameDone = 1'b0;
    next_destMatch = destMatch;
    accept = (state == mfe_pkg::MFE_RX_IDLE) ? rx.rxEnable : (state == mfe_pkg::MFE_RX_ACCEPT);
    matchNow = ((state == mfe_pkg::MFE_RX_IDLE) ? 1'b1 : match) &&
               ((((state == mfe_pkg::MFE_RX_IDLE) ? 4'h0 : cnt) >= mfe_pkg::DST_END) ||
                (rx.inData == mfe_pkg::mfe_addr_byte(rx.stationAddr,
                  ((state == mfe_pkg::MFE_RX_IDLE) ? 3'h0 : cnt[2:0]))));
    if (rx.inValid) begin
      next_match = matchNow;
      next_cnt = (state == mfe_pkg::MFE_RX_IDLE) ? 4'h1 : ((cnt == 4'hf) ? cnt : cnt + 4'h1);
      next_state = accept ? mfe_pkg::MFE_RX_ACCEPT : mfe_pkg::MFE_RX_DROP;
      next_outValid = accept;
      next_outData = rx.inData;
      next_outLast = accept && rx.inLast;
      if (rx.inLast) begin
        next_state = mfe_pkg::MFE_RX_IDLE;
        next_frameDone = accept;
        next_destMatch = accept ? matchNow : destMatch;
      end
    end
  end

  // Register the filter state and its outputs.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      state <= mfe_pkg::MFE_RX_IDLE;
      cnt <= 4'h0;
      match <= 1'b0;
      outValid <= 1'b0;
      outData <= 8'h00;
      outLast <= 1'b0;
      frameDone <= 1'b0;
      destMatch <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      match <= next_match;
      outValid <= next_outValid;
      outData <= next_outData;
      outLast <= next_outLast;
      frameDone <= next_frameDone;
      destMatch <= next_destMatch;
    end
  end

  assign rx.outValid = outValid;
  assign rx.outData = outData;
  assign rx.outLast = outLast;
  assign rx.frameDone = frameDone;
  assign rx.destMatch = destMatch;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_rx_drop_off: assert property (@(posedge core_clk) disable iff (!rstSync)
    state == mfe_pkg::MFE_RX_IDLE && rx.inValid && !rx.rxEnable
      |=> !outValid until (state == mfe_pkg::MFE_RX_IDLE))
    else $error("Byte passed while receive was disabled.");
  a_rx_take_on: assert property (@(posedge core_clk) disable iff (!rstSync)
    state == mfe_pkg::MFE_RX_IDLE && rx.inValid && rx.rxEnable
      |=> outValid && outData == $past(rx.inData))
    else $error("First byte of an enabled frame was lost.");
  c_rx_match: cover property (@(posedge core_clk) disable iff (!rstSync)
    frameDone && destMatch);

endmodule : mfe_rx_filter

//--- mfe_mac_regs.sv
// Top of the MAC enable and station address block: APB registers, EEPROM
// load path, transmit gate with source address insertion, receive filter.
// Assumes a zero-wait APB master and an EEPROM controller that presents
// one byte per strobe and pulses its done signal once after power-on.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
module mfe_mac_regs (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // EEPROM controller load path.
  input wire logic eeByteValid,
  input wire logic [7:0] eeByteAddr,
  input wire logic [7:0] eeByteData,
  input wire logic eeProgrammed,
  input wire logic eeLoadDone,
  // Transmit buffer side.
  input wire logic txBufValid,
  input wire logic [7:0] txBufData,
  input wire logic txBufLast,
  output logic txBufReady,
  // Transmit PHY side.
  output logic txPhyValid,
  output logic [7:0] txPhyData,
  output logic txPhyLast,
  input wire logic txPhyReady,
  // Receive PHY side.
  input wire logic rxPhyValid,
  input wire logic [7:0] rxPhyData,
  input wire logic rxPhyLast,
  // Received frame output.
  output logic rxOutValid,
  output logic [7:0] rxOutData,
  output logic rxOutLast,
  output logic rxFrameDone,
  output logic rxDestMatch
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  logic rstMeta, rstSync;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file.
  logic txEnable, next_txEnable;
  logic rxEnable, next_rxEnable;
  logic [15:0] addrHigh, next_addrHigh;
  logic [31:0] addrLow, next_addrLow;
  logic initDone, next_initDone;
  logic [31:0] next_prdata;
  logic wrEn, eeTake;
  logic [47:0] stationAddr;
  mfe_pkg::mfe_tx_state_e txState;

  // True for any address that a register answers.
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == mfe_pkg::REG_CTRL_ADDR) || (a == mfe_pkg::REG_STATION_ADDR_HIGH_ADDR) ||
                 (a == mfe_pkg::REG_STATION_ADDR_LOW_ADDR) || (a == mfe_pkg::REG_STATUS_ADDR);
  endfunction : reg_mapped

  // Zero-wait slave; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_mapped(paddr);
  assign wrEn = psel && penable && pwrite;
  assign eeTake = eeByteValid && eeProgrammed && !initDone;
  assign stationAddr = {addrHigh, addrLow};

  // Next register values from host writes and the EEPROM load.
  always_comb begin
    next_txEnable = txEnable;
    next_rxEnable = rxEnable;
    next_addrHigh = addrHigh;
    next_addrLow = addrLow;
    next_initDone = initDone || eeLoadDone;
    next_prdata = prdata;
    if (wrEn && paddr == mfe_pkg::REG_CTRL_ADDR) begin
      next_txEnable = pwdata[mfe_pkg::CTRL_TRANSMIT_ENABLE_BIT_BIT];
      next_rxEnable = pwdata[mfe_pkg::CTRL_RECEIVE_ENABLE_BIT_BIT];
    end
    if (wrEn && initDone && paddr == mfe_pkg::REG_STATION_ADDR_HIGH_ADDR) begin
      next_addrHigh = pwdata[15:0];
    end
    if (wrEn && initDone && paddr == mfe_pkg::REG_STATION_ADDR_LOW_ADDR) begin
      next_addrLow = pwdata;
    end
    // Load only from a programmed EEPROM.
    if (eeTake) begin
      case (eeByteAddr)
        mfe_pkg::EE_STATION_ADDR_LOW_B0: next_addrLow[7:0] = eeByteData;
        mfe_pkg::EE_STATION_ADDR_LOW_B1: next_addrLow[15:8] = eeByteData;
        mfe_pkg::EE_STATION_ADDR_LOW_B2: next_addrLow[23:16] = eeByteData;
        mfe_pkg::EE_STATION_ADDR_LOW_B3: next_addrLow[31:24] = eeByteData;
        mfe_pkg::EE_STATION_ADDR_HIGH_B0: next_addrHigh[7:0] = eeByteData;
        mfe_pkg::EE_STATION_ADDR_HIGH_B1: next_addrHigh[15:8] = eeByteData;
        default: next_addrHigh = addrHigh;
      endcase
    end
    // Read data is captured in the setup cycle and stands through access.
    if (psel && !penable && !pwrite) begin
      if (paddr == mfe_pkg::REG_CTRL_ADDR) begin
        next_prdata = 32'h0000_0000;
        next_prdata[mfe_pkg::CTRL_TRANSMIT_ENABLE_BIT_BIT] = txEnable;
        next_prdata[mfe_pkg::CTRL_RECEIVE_ENABLE_BIT_BIT] = rxEnable;
      end else if (paddr == mfe_pkg::REG_STATION_ADDR_HIGH_ADDR) begin
        next_prdata = {16'h0000, addrHigh};
      end else if (paddr == mfe_pkg::REG_STATION_ADDR_LOW_ADDR) begin
        next_prdata = addrLow;
      end else if (paddr == mfe_pkg::REG_STATUS_ADDR) begin
        next_prdata = 32'h0000_0000;
        next_prdata[mfe_pkg::STAT_INIT_BIT] = initDone;
        next_prdata[mfe_pkg::STAT_TXBUSY_BIT] = (txState == mfe_pkg::MFE_TX_SEND);
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  // Register the file; address high resets to its documented value.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      txEnable <= mfe_pkg::CTRL_TRANSMIT_ENABLE_BIT_RESET;
      rxEnable <= mfe_pkg::CTRL_RECEIVE_ENABLE_BIT_RESET;
      addrHigh <= mfe_pkg::STATION_ADDR_HIGH_RESET[15:0];
      addrLow <= mfe_pkg::STATION_ADDR_LOW_RESET;
      initDone <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      txEnable <= next_txEnable;
      rxEnable <= next_rxEnable;
      addrHigh <= next_addrHigh;
      addrLow <= next_addrLow;
      initDone <= next_initDone;
      prdata <= next_prdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit gate with source address insertion.
  mfe_pkg::mfe_tx_state_e next_txState;
  logic [3:0] txCnt, next_txCnt;
  logic next_txPhyValid, next_txPhyLast;
  logic [7:0] next_txPhyData;
  logic txTake;
  logic [3:0] txIdx;

  // Frames start only while enabled; a disabled idle gate stalls the buffer.
  assign txBufReady = (!txPhyValid || txPhyReady) &&
                      (txState == mfe_pkg::MFE_TX_SEND || txEnable);
  assign txTake = txBufValid && txBufReady;
  assign txIdx = (txState == mfe_pkg::MFE_TX_IDLE) ? 4'h0 : txCnt;

  // Move one byte per take; a started frame always runs to its last byte.
  always_comb begin
    next_txState = txState;
    next_txCnt = txCnt;
    next_txPhyValid = txPhyValid && !txPhyReady;
    next_txPhyData = txPhyData;
    next_txPhyLast = txPhyLast;
    if (txTake) begin
      next_txPhyValid = 1'b1;
      next_txPhyLast = txBufLast;
      next_txPhyData = txBufData;
      if (txIdx >= mfe_pkg::SRC_FIRST && txIdx < mfe_pkg::SRC_END) begin
        next_txPhyData = mfe_pkg::mfe_addr_byte(stationAddr, 3'(txIdx - mfe_pkg::SRC_FIRST));
      end
      next_txCnt = (txIdx == 4'hf) ? txIdx : txIdx + 4'h1;
      next_txState = txBufLast ? mfe_pkg::MFE_TX_IDLE : mfe_pkg::MFE_TX_SEND;
    end
  end

  // Register the transmit stage.
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      txState <= mfe_pkg::MFE_TX_IDLE;
      txCnt <= 4'h0;
      txPhyValid <= 1'b0;
      txPhyData <= 8'h00;
      txPhyLast <= 1'b0;
    end else begin
      txState <= next_txState;
      txCnt <= next_txCnt;
      txPhyValid <= next_txPhyValid;
      txPhyData <= next_txPhyData;
      txPhyLast <= next_txPhyLast;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive filter.
  mfe_rx_if rxLink();

  assign rxLink.stationAddr = stationAddr;
  assign rxLink.rxEnable = rxEnable;
  assign rxLink.inValid = rxPhyValid;
  assign rxLink.inData = rxPhyData;
  assign rxLink.inLast = rxPhyLast;
  assign rxOutValid = rxLink.outValid;
  assign rxOutData = rxLink.outData;
  assign rxOutLast = rxLink.outLast;
  assign rxFrameDone = rxLink.frameDone;
  assign rxDestMatch = rxLink.destMatch;

  mfe_rx_filter uRxFilter (
    .core_clk(core_clk),
    .rstSync(rstSync),
    .rx(rxLink.filt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync);

  a_tx_idle_off: assert property (txState == mfe_pkg::MFE_TX_IDLE && !txEnable |-> !txBufReady)
    else $error("Transmit buffer drained while disabled.");
  a_tx_flow_on: assert property (txEnable && !txPhyValid |-> txBufReady)
    else $error("Enabled transmitter refused a byte.");
  a_tx_src_byte: assert property (txTake && txIdx == mfe_pkg::SRC_FIRST
      |=> txPhyValid && txPhyData == $past(addrLow[7:0]))
    else $error("Source byte is not the station address.");
  a_station_addr_high_reset_val: assert property ($rose(rstSync) |-> addrHigh == 16'h0fff)
    else $error("Address high has a wrong reset value.");
  a_station_addr_high_rsvd_zero: assert property (psel && !penable && !pwrite
      && paddr == mfe_pkg::REG_STATION_ADDR_HIGH_ADDR
      |=> prdata[31:16] == 16'h0000 && prdata[15:0] == $past(addrHigh))
    else $error("Address high read data wrong.");
  a_ee_low_byte: assert property (eeTake && eeByteAddr == mfe_pkg::EE_STATION_ADDR_HIGH_B0
      |=> addrHigh[7:0] == $past(eeByteData))
    else $error("EEPROM byte 0x05 not loaded.");
  a_ee_high_byte: assert property (eeTake && eeByteAddr == mfe_pkg::EE_STATION_ADDR_HIGH_B1
      |=> addrHigh[15:8] == $past(eeByteData))
    else $error("EEPROM byte 0x06 not loaded.");
  a_ee_blank_keep: assert property (!eeProgrammed && !initDone |=> $stable(addrHigh))
    else $error("Address changed without a programmed EEPROM.");
  a_host_write_keep: assert property (wrEn && initDone && paddr == mfe_pkg::REG_STATION_ADDR_HIGH_ADDR
      |=> addrHigh == $past(pwdata[15:0]) ##1 addrHigh == $past(addrHigh))
    else $error("Host write to address high not kept.");
  a_ctrl_rx_write: assert property (wrEn && paddr == mfe_pkg::REG_CTRL_ADDR
      |=> rxEnable == $past(pwdata[mfe_pkg::CTRL_RECEIVE_ENABLE_BIT_BIT]))
    else $error("Receive enable write not taken.");
  c_tx_frame: cover property (txPhyValid && txPhyReady && txPhyLast);
  c_ee_load: cover property (eeTake ##[1:20] initDone);
  c_host_write: cover property (wrEn && initDone && paddr == mfe_pkg::REG_STATION_ADDR_HIGH_ADDR);

endmodule : mfe_mac_regs

//--- mfe_far_model.sv
// Behavioural far side of the block: the EEPROM controller load path
// and the transmit side of the PHY.
// Assumes core_clk and the raw active-low reset of the block under test.
`timescale 1ns/1ns
module mfe_far_model #(
  parameter logic [47:0] EE_ADDR = 48'h2d_e1_3c_96_c3_5a
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Pace chosen by the bench.
  input wire logic slow,
  // EEPROM controller load path.
  output logic eeByteValid,
  output logic [7:0] eeByteAddr,
  output logic [7:0] eeByteData,
  output logic eeProgrammed,
  output logic eeLoadDone,
  // PHY transmit side.
  output logic txPhyReady
);
  logic [1:0] pace = 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Slow mode takes one byte in four, so the MAC must hold its byte.
  always_ff @(posedge core_clk) begin
    pace <= pace + 2'h1;
  end
  assign txPhyReady = !slow || pace == 2'h0;

  // Presents one byte for one cycle, then shows the inverse on the released lines.
  task automatic send(input logic [7:0] a, input logic [7:0] d);
    eeByteValid <= 1'b1;
    eeByteAddr <= a;
    eeByteData <= d;
    @(posedge core_clk);
    eeByteValid <= 1'b0;
    eeByteAddr <= ~a;
    eeByteData <= ~d;
    @(posedge core_clk);
  endtask : send

  //////////////////////////////////////////////////////////////////////////////
  // Power-on load: bytes 1 to 6, a stray byte 7, done, then a late byte.
  initial begin
    eeByteValid = 1'b0;
    eeByteAddr = 8'h00;
    eeByteData = 8'h00;
    eeProgrammed = 1'b0;
    eeLoadDone = 1'b0;
    @(posedge rst_n);
    repeat (2) @(posedge core_clk);
    // A byte offered while no programmed EEPROM is seen must be ignored.
    send(mfe_pkg::EE_STATION_ADDR_HIGH_B1, 8'h00);
    eeProgrammed <= 1'b1;
    repeat (6) @(posedge core_clk);
    for (int k = 1; k <= 7; k++) begin
      send(k[7:0], (k <= 6) ? EE_ADDR[8*(k-1) +: 8] : 8'h77);
    end
    eeLoadDone <= 1'b1;
    @(posedge core_clk);
    eeLoadDone <= 1'b0;
    @(posedge core_clk);
    send(mfe_pkg::EE_STATION_ADDR_HIGH_B0, 8'h00);
  end
endmodule : mfe_far_model

//--- mfe_mac_regs_tb.sv
// Self-checking bench for the MAC enable and station address block.
// Assumes the far side model for EEPROM load and PHY transmit pacing.
`timescale 1ns/1ns
module mfe_mac_regs_tb;
  localparam logic [47:0] EE_ADDR = 48'h2d_e1_3c_96_c3_5a;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0] paddr, eeByteAddr, eeByteData, txBufData, txPhyData, rxPhyData, rxOutData;
  logic [31:0] pwdata, prdata, seed;
  logic eeByteValid, eeProgrammed, eeLoadDone, txBufValid, txBufLast, txBufReady;
  logic txPhyValid, txPhyLast, txPhyReady, rxPhyValid, rxPhyLast;
  logic rxOutValid, rxOutLast, rxFrameDone, rxDestMatch;
  logic [47:0] stationAddr;
  logic [32:0] rdQ[$], txQ[$], rxQ[$], matchQ[$];
  int fails = 0;
  int comparisons = 0;

  mfe_mac_regs mfe_mac_regs_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eeByteValid(eeByteValid),
    .eeByteAddr(eeByteAddr), .eeByteData(eeByteData), .eeProgrammed(eeProgrammed),
    .eeLoadDone(eeLoadDone), .txBufValid(txBufValid), .txBufData(txBufData),
    .txBufLast(txBufLast), .txBufReady(txBufReady), .txPhyValid(txPhyValid),
    .txPhyData(txPhyData), .txPhyLast(txPhyLast), .txPhyReady(txPhyReady),
    .rxPhyValid(rxPhyValid), .rxPhyData(rxPhyData), .rxPhyLast(rxPhyLast),
    .rxOutValid(rxOutValid), .rxOutData(rxOutData), .rxOutLast(rxOutLast),
    .rxFrameDone(rxFrameDone), .rxDestMatch(rxDestMatch));

  mfe_far_model #(.EE_ADDR(EE_ADDR)) mfe_far_model_i (.core_clk(core_clk),
    .rst_n(rst_n), .slow(slow), .eeByteValid(eeByteValid), .eeByteAddr(eeByteAddr),
    .eeByteData(eeByteData), .eeProgrammed(eeProgrammed), .eeLoadDone(eeLoadDone),
    .txPhyReady(txPhyReady));

  //////////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction : lfsr

  // An empty queue yields unknown, so an unexpected result always fails.
  function automatic logic [32:0] pop(ref logic [32:0] q[$]);
    pop = (q.size() != 0) ? q.pop_front() : 'x;
  endfunction : pop

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d.", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h.", nm, e, g);
    end
  endtask : chk

  task automatic give_up(input string nm);
    fails++;
    $display("[FAIL] %s expected done seen timeout.", nm);
    stop_test();
  endtask : give_up

  //////////////////////////////////////////////////////////////////////////////
  // APB master: setup, then access until pready is high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) give_up("pready");
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never rewrites psel in this time step.
    @(posedge core_clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    rdQ.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Sends one frame; bytes 6 to 11 are expected to carry the station address.
  task automatic tx_frame(input int n);
    int t;
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      txQ.push_back({24'h0, i == n - 1, (i >= 6 && i < 12) ? stationAddr[8*(i-6) +: 8] : d});
      txBufValid <= 1'b1;
      txBufData <= d;
      txBufLast <= (i == n - 1);
      t = 0;
      do begin
        @(posedge core_clk);
        t++;
      end while (txBufReady !== 1'b1 && t < 100);
      if (t >= 100) give_up("txBufReady");
    end
  endtask : tx_frame

  // PHY receive frame with destination dst; acc marks an expected acceptance.
  task automatic rx_frame(input logic [47:0] dst, input int n, input logic acc,
                          input logic match);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      d = (i < 6) ? dst[8*i +: 8] : seed[7:0];
      if (acc) rxQ.push_back({24'h0, i == n - 1, d});
      rxPhyValid <= 1'b1;
      rxPhyData <= d;
      rxPhyLast <= (i == n - 1);
      @(posedge core_clk);
    end
    if (acc) matchQ.push_back({32'h0, match});
  endtask : rx_frame

  //////////////////////////////////////////////////////////////////////////////
  // Result watcher: every completed read or output byte takes the oldest note.
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", pop(rdQ), {pslverr, prdata});
    end
    if (txPhyValid === 1'b1 && txPhyReady) begin
      chk("txPhy", pop(txQ), {24'h0, txPhyLast, txPhyData});
    end
    if (rxOutValid === 1'b1) begin
      chk("rxOut", pop(rxQ), {24'h0, rxOutLast, rxOutData});
    end
    if (rxFrameDone === 1'b1) begin
      chk("rxDestMatch", pop(matchQ), {32'h0, rxDestMatch});
    end
  end

  // Watchdog on the whole run.
  initial begin
    repeat (20000) @(posedge core_clk);
    give_up("run");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int n;
    {rst_n, psel, penable, pwrite, slow, txBufValid, txBufLast, rxPhyValid} = 8'h00;
    {rxPhyLast, paddr, pwdata, txBufData, rxPhyData} = 57'h0;
    seed = 32'h88cd_b5c8;
    stationAddr = EE_ADDR;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(mfe_pkg::REG_STATION_ADDR_HIGH_ADDR, 32'h0000_0fff, 1'b0);
    rd(mfe_pkg::REG_CTRL_ADDR, 32'h0, 1'b0);
    apb(1'b1, mfe_pkg::REG_STATION_ADDR_HIGH_ADDR, 32'h0000_1234);
    rd(mfe_pkg::REG_STATION_ADDR_HIGH_ADDR, 32'h0000_0fff, 1'b0);
    $display("Reset values done.");
    n = 0;
    while (eeLoadDone !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 300) give_up("eeLoadDone");
    repeat (8) @(posedge core_clk);
    rd(mfe_pkg::REG_STATUS_ADDR, 32'h1, 1'b0);
    rd(mfe_pkg::REG_STATION_ADDR_HIGH_ADDR, {16'h0, EE_ADDR[47:32]}, 1'b0);
    rd(mfe_pkg::REG_STATION_ADDR_LOW_ADDR, EE_ADDR[31:0], 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    seed = lfsr(seed);
    apb(1'b1, mfe_pkg::REG_STATION_ADDR_HIGH_ADDR, seed | 32'hffff_0000);
    stationAddr[47:32] = seed[15:0];
    rd(mfe_pkg::REG_STATION_ADDR_HIGH_ADDR, {16'h0, seed[15:0]}, 1'b0);
    $display("Load and overwrite done.");
    txBufValid <= 1'b1;
    txBufData <= 8'h55;
    repeat (20) @(negedge core_clk);
    chk("txBufReady", 33'h0, {32'h0, txBufReady});
    @(posedge core_clk);
    txBufValid <= 1'b0;
    apb(1'b1, mfe_pkg::REG_CTRL_ADDR, 32'h1 << mfe_pkg::CTRL_TRANSMIT_ENABLE_BIT_BIT);
    tx_frame(14);
    slow <= 1'b1;
    tx_frame(13);
    txBufValid <= 1'b0;
    n = 0;
    while (txQ.size() != 0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 200) give_up("txQ");
    $display("Transmit done.");
    rx_frame(stationAddr, 9, 1'b0, 1'b0);
    rxPhyValid <= 1'b0;
    apb(1'b1, mfe_pkg::REG_CTRL_ADDR, 32'hc);
    rx_frame(stationAddr, 12, 1'b1, 1'b1);
    rx_frame(stationAddr ^ 48'h0100, 8, 1'b1, 1'b0);
    rxPhyValid <= 1'b0;
    rxPhyData <= ~rxPhyData;
    repeat (6) @(posedge core_clk);
    chk("pending", 33'h0, 33'(txQ.size() + rxQ.size() + matchQ.size() + rdQ.size()));
    $display("Receive done.");
    stop_test();
  end
endmodule : mfe_mac_regs_tb
